// file: hw/port_p0_p1_defines.svh
// Offsets, reset values and field positions of the two-port I/O block
// Included by the port design module and the testbench
`ifndef PORT_P0_P1_DEFINES_SVH
`define PORT_P0_P1_DEFINES_SVH
`define ADDR_PORT0_OUTPUT_LATCH 6'h00
`define ADDR_PORT1_OUTPUT_LATCH 6'h01
`define ADDR_PORT0_PIN_LEVELS 6'h08
`define ADDR_PORT1_DIRECTION_CONTROL 6'h0D
`define ADDR_EXTERNAL_INTERRUPT_CONTROL 6'h37
`define RESET_PORT0_OUTPUT_LATCH 8'hFF
`define RESET_PORT1_OUTPUT_LATCH 6'h00
`define RESET_PORT1_DIRECTION_CONTROL 6'h00
`define RESET_EXTERNAL_INTERRUPT_CONTROL 8'h00
`define POS_PIN0_INTERRUPT_SELECT 6
`define PORT1_WIDTH 6
`define UNDEFINED_HIGH_BITS 2'h0
`endif

// file: hw/port_p0_p1_pkg.sv
// Types shared by the two-port I/O block
// Assumes the defines header is on the include path
package port_p0_p1_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef struct packed {
    logic [5:0] oe;
    logic [5:0] out;
  } port1_drive_t;
endpackage

// file: hw/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
// Assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule // pin_sync
`default_nettype wire

// file: hw/parallel_port_p0_p1.sv
// Port 0 and port 1 parallel I/O with their special-function registers
// Assumes the CPU presents one-cycle rd/wr strobes in the read and write cycle states
// Behaviour
// - Reset loads all port-0 output latch bits with one.
// - Port-0 latch address reads latch; pin-level address reads port-0 pins.
// - Interrupt select bit chooses plain I/O or interrupt input; reset gives I/O.
// - Port-0 pins also carry interrupt, serial and timer secondary functions.
// - Port 1 has six bits, direction bit zero input, one output.
// - Reset clears port-1 direction bits and port-1 output latch.
// - Port-1 latch is writable whatever the direction.
// - Bits 7 and 6 of port-1 latch and direction read undefined; the code reads them as zero.
// - Port-1 data read gives pins for inputs and latch for outputs.
// - Input data is sampled in the read sample state.
// - Output latches load in the write update state; pin drivers follow one clock later.
// - Select zero gives port-0 bit 0 as I/O, one as interrupt zero input.
`timescale 1ns/1ps
`default_nettype none
`include "port_p0_p1_defines.svh"
module parallel_port_p0_p1 (
  input wire logic clk,
  input wire logic rst_n,
  input wire port_p0_p1_pkg::sfr_req_t req,
  input wire logic readSampleState,
  input wire logic writeUpdateState,
  output logic [7:0] rdata,
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic [7:0] port0Oe,
  input wire logic [5:0] port1In,
  output port_p0_p1_pkg::port1_drive_t port1Drive,
  output logic externalInterruptZeroInput,
  output logic [7:0] port0SecondaryIn,
  input wire logic [7:0] port0SecondaryOut,
  output logic [5:0] port1SecondaryIn,
  input wire logic [5:0] port1SecondaryOut,
  input wire logic [5:0] port1SecondaryEn
);
  logic [7:0] port0OutputLatch;
  logic [5:0] port1OutputLatch;
  logic [5:0] port1DirectionControl;
  logic [7:0] externalInterruptControl;
  logic [7:0] port0Pins;
  logic [5:0] port1Pins;
  logic wrHit;
  logic rdHit;
  logic [7:0] next_rdata;

  pin_sync #(.W(8)) syncPort0 (.clk(clk), .d(port0In), .q(port0Pins));
  pin_sync #(.W(6)) syncPort1 (.clk(clk), .d(port1In), .q(port1Pins));

  assign wrHit = req.wr && writeUpdateState;
  assign rdHit = req.rd && readSampleState;

  // Port-0 latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port0OutputLatch <= `RESET_PORT0_OUTPUT_LATCH;
    end else if (wrHit && req.addr == `ADDR_PORT0_OUTPUT_LATCH) begin
      port0OutputLatch <= req.wdata;
    end
  end

  // Port-1 latch, accepted regardless of direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port1OutputLatch <= `RESET_PORT1_OUTPUT_LATCH;
    end else if (wrHit && req.addr == `ADDR_PORT1_OUTPUT_LATCH) begin
      port1OutputLatch <= req.wdata[5:0];
    end
  end

  // Port-1 direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port1DirectionControl <= `RESET_PORT1_DIRECTION_CONTROL;
    end else if (wrHit && req.addr == `ADDR_PORT1_DIRECTION_CONTROL) begin
      port1DirectionControl <= req.wdata[5:0];
    end
  end

  // Interrupt control, only the pin-0 select acts here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      externalInterruptControl <= `RESET_EXTERNAL_INTERRUPT_CONTROL;
    end else if (wrHit && req.addr == `ADDR_EXTERNAL_INTERRUPT_CONTROL) begin
      externalInterruptControl <= req.wdata;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    case (req.addr)
      `ADDR_PORT0_OUTPUT_LATCH: next_rdata = port0OutputLatch;
      `ADDR_PORT0_PIN_LEVELS: next_rdata = port0Pins;
      `ADDR_PORT1_OUTPUT_LATCH: begin
        next_rdata = {`UNDEFINED_HIGH_BITS,
          (port1DirectionControl & port1OutputLatch)
          | (~port1DirectionControl & port1Pins)};
      end
      `ADDR_PORT1_DIRECTION_CONTROL: begin
        next_rdata = {`UNDEFINED_HIGH_BITS, port1DirectionControl};
      end
      `ADDR_EXTERNAL_INTERRUPT_CONTROL: next_rdata = externalInterruptControl;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rdHit) begin
      rdata <= next_rdata;
    end
  end

  // Pin drivers: port 0 open drain, secondary output ANDs into the latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port0Out <= 8'h00;
      port0Oe <= 8'h00;
    end else begin
      port0Out <= 8'h00;
      port0Oe <= ~(port0OutputLatch & port0SecondaryOut);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port1Drive <= '0;
    end else begin
      port1Drive.oe <= port1DirectionControl;
      port1Drive.out <= port1OutputLatch
        & (~port1SecondaryEn | port1SecondaryOut);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      externalInterruptZeroInput <= 1'b1;
      port0SecondaryIn <= 8'hFF;
      port1SecondaryIn <= 6'h00;
    end else begin
      externalInterruptZeroInput <= externalInterruptControl[`POS_PIN0_INTERRUPT_SELECT]
        ? port0Pins[0] : 1'b1;
      port0SecondaryIn <= port0Pins;
      port1SecondaryIn <= port1Pins & ~port1DirectionControl;
    end
  end

  property p_port0_reset;
    @(posedge clk) !rst_n |=> port0OutputLatch == 8'hFF;
  endproperty
  a_port0_reset: assert property (p_port0_reset) else $error("port0 latch not all ones");

  property p_port1_reset;
    @(posedge clk) !rst_n |=> port1OutputLatch == 6'h00 && port1DirectionControl == 6'h00;
  endproperty
  a_port1_reset: assert property (p_port1_reset) else $error("port1 not cleared");

  sequence s_p1_write;
    wrHit && req.addr == `ADDR_PORT1_OUTPUT_LATCH;
  endsequence
  property p_p1_write_any_dir;
    @(posedge clk) disable iff (!rst_n)
      s_p1_write |=> port1OutputLatch == $past(req.wdata[5:0]);
  endproperty
  a_p1_write_any_dir: assert property (p_p1_write_any_dir) else $error("p1 write lost");

  property p_no_write_outside;
    @(posedge clk) disable iff (!rst_n)
      req.wr && !writeUpdateState |=> $stable(port0OutputLatch);
  endproperty
  a_no_write_outside: assert property (p_no_write_outside) else $error("write off state");

  property p_pin_read;
    @(posedge clk) disable iff (!rst_n)
      rdHit && req.addr == `ADDR_PORT0_PIN_LEVELS |=> rdata == $past(port0Pins);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

  property p_p1_high_zero;
    @(posedge clk) disable iff (!rst_n)
      rdHit && req.addr == `ADDR_PORT1_DIRECTION_CONTROL |=> rdata[7:6] == 2'b00;
  endproperty
  a_p1_high_zero: assert property (p_p1_high_zero) else $error("p1 high bits");

  property p_p1_mix;
    @(posedge clk) disable iff (!rst_n)
      rdHit && req.addr == `ADDR_PORT1_OUTPUT_LATCH |=>
        rdata[5:0] == (($past(port1DirectionControl) & $past(port1OutputLatch))
        | (~$past(port1DirectionControl) & $past(port1Pins)));
  endproperty
  a_p1_mix: assert property (p_p1_mix) else $error("p1 read mix");

  property p_rdata_hold;
    @(posedge clk) disable iff (!rst_n) !rdHit |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");

  property p_open_drain;
    @(posedge clk) disable iff (!rst_n)
      port0OutputLatch[3] && port0SecondaryOut[3] |=> !port0Oe[3] && !port0Out[3];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("p0 not released");

  property p_external_interrupt_zero_input_sel;
    @(posedge clk) disable iff (!rst_n)
      !externalInterruptControl[`POS_PIN0_INTERRUPT_SELECT] |=> externalInterruptZeroInput;
  endproperty
  a_external_interrupt_zero_input_sel: assert property (p_external_interrupt_zero_input_sel) else $error("external_interrupt_zero_input leaked");
endmodule // parallel_port_p0_p1
`default_nettype wire

// file: verification/board_pins_model.sv
// Board model on the port pins of the two-port block
// Assumes port 0 pins have pull-ups and port 1 pins follow the board when undriven
`timescale 1ns/1ps
`default_nettype none
module board_pins_model (
  input wire logic [7:0] port0Oe,
  input wire port_p0_p1_pkg::port1_drive_t port1Drive,
  input wire logic [7:0] board0,
  input wire logic [5:0] board1,
  output logic [7:0] port0In,
  output logic [5:0] port1In
);
  // Pulled pins read low, released pins the board level
  assign port0In = ~port0Oe & board0;
  // Output bits show the drive, input bits the board
  assign port1In = (port1Drive.oe & port1Drive.out) | (~port1Drive.oe & board1);
endmodule // board_pins_model
`default_nettype wire

// file: verification/parallel_port_p0_p1_tb.sv
// Self-checking bench for the two-port I/O block
// Assumes the board model and the defines header are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "port_p0_p1_defines.svh"
module parallel_port_p0_p1_tb;
  logic clk, rst_n, readSampleState, writeUpdateState, intZero;
  port_p0_p1_pkg::sfr_req_t req;
  port_p0_p1_pkg::port1_drive_t port1Drive;
  logic [7:0] rdata, port0In, port0Oe, port0SecIn, board0;
  logic [5:0] port1In, port1SecIn, board1;
  logic [7:0] port0Out, sec0Out;
  logic [5:0] sec1Out, sec1En;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  parallel_port_p0_p1 dut (.clk(clk), .rst_n(rst_n), .req(req),
    .readSampleState(readSampleState), .writeUpdateState(writeUpdateState), .rdata(rdata),
    .port0In(port0In), .port0Out(port0Out), .port0Oe(port0Oe), .port1In(port1In),
    .port1Drive(port1Drive), .externalInterruptZeroInput(intZero),
    .port0SecondaryIn(port0SecIn), .port0SecondaryOut(sec0Out), .port1SecondaryIn(port1SecIn),
    .port1SecondaryOut(sec1Out), .port1SecondaryEn(sec1En));
  board_pins_model model (.port0Oe(port0Oe), .port1Drive(port1Drive), .board0(board0),
    .board1(board1), .port0In(port0In), .port1In(port1In));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      results();
    end
  end
  task automatic results();
    $display("Tests %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    writeUpdateState <= 1'b1;
    @(posedge clk);
    req <= '0;
    writeUpdateState <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    readSampleState <= 1'b1;
    @(posedge clk);
    req <= '0;
    readSampleState <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic t_reset();
    #1 chk(port0Oe, 8'h00);
    chk(port0Out, 8'h00);
    chk({2'h0, port1Drive.oe}, 8'h00);
    chk({2'h0, port1Drive.out}, 8'h00);
    chk({7'h00, intZero}, 8'h01);
    rd(`ADDR_PORT0_OUTPUT_LATCH, 8'hFF);
    rd(`ADDR_PORT1_DIRECTION_CONTROL, 8'h00);
  endtask
  task automatic t_port0();
    wr(`ADDR_PORT0_OUTPUT_LATCH, 8'h5A);
    @(posedge clk);
    #1 chk(port0Oe, 8'hA5);
    repeat (3) @(posedge clk);
    rd(`ADDR_PORT0_PIN_LEVELS, 8'h0A);
    rd(`ADDR_PORT0_OUTPUT_LATCH, 8'h5A);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: `ADDR_PORT0_OUTPUT_LATCH, wdata: 8'h00};
    rd(`ADDR_PORT0_OUTPUT_LATCH, 8'h5A);
    wr(`ADDR_PORT0_OUTPUT_LATCH, 8'hFF);
    rd(`ADDR_PORT0_OUTPUT_LATCH, 8'hFF);
  endtask
  task automatic t_port1();
    @(posedge clk);
    board1 <= 6'h2A;
    wr(`ADDR_PORT1_OUTPUT_LATCH, 8'h15);
    repeat (3) @(posedge clk);
    rd(`ADDR_PORT1_OUTPUT_LATCH, 8'h2A);
    wr(`ADDR_PORT1_DIRECTION_CONTROL, 8'hCF);
    repeat (3) @(posedge clk);
    #1 chk({2'h0, port1Drive.oe}, 8'h0F);
    chk({2'h0, port1Drive.out}, 8'h15);
    chk({2'h0, port1SecIn}, 8'h20);
    rd(`ADDR_PORT1_DIRECTION_CONTROL, 8'h0F);
    rd(`ADDR_PORT1_OUTPUT_LATCH, 8'h25);
  endtask
  task automatic t_external_interrupt_zero_input();
    @(posedge clk);
    board0 <= 8'hFE;
    wr(`ADDR_EXTERNAL_INTERRUPT_CONTROL, 8'h40);
    repeat (4) @(posedge clk);
    #1 chk({7'h00, intZero}, 8'h00);
    chk(port0SecIn, 8'hFE);
    rd(`ADDR_EXTERNAL_INTERRUPT_CONTROL, 8'h40);
    wr(`ADDR_EXTERNAL_INTERRUPT_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, intZero}, 8'h01);
  endtask
  task automatic t_secondary();
    @(posedge clk);
    sec0Out <= 8'hF7;
    repeat (5) @(posedge clk);
    #1 chk(port0Oe, 8'h08);
    chk(port0Out, 8'h00);
    chk(port0SecIn, 8'hF6);
    wr(`ADDR_PORT1_OUTPUT_LATCH, 8'h3F);
    sec1En <= 6'h30;
    sec1Out <= 6'h10;
    wr(`ADDR_PORT1_DIRECTION_CONTROL, 8'h3F);
    repeat (2) @(posedge clk);
    #1 chk({2'h0, port1Drive.out}, 8'h1F);
    chk({2'h0, port1Drive.oe}, 8'h3F);
    rd(`ADDR_PORT1_OUTPUT_LATCH, 8'h3F);
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    readSampleState = 1'b0;
    writeUpdateState = 1'b0;
    board0 = 8'h0F;
    board1 = 6'h00;
    sec0Out = 8'hFF;
    sec1Out = 6'h00;
    sec1En = 6'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_port0();
    t_port1();
    t_external_interrupt_zero_input();
    t_secondary();
    results();
  end
endmodule // parallel_port_p0_p1_tb
`default_nettype wire
